// *** include/gpio_pkg.sv ***
// shared constants for the general-purpose port bank
package gpio_pkg;
	localparam int          PORT_W       = 8;
	localparam int          APB_ADDR_W   = 14;
	localparam int          IDX_W        = 12;
	localparam int          IDX_STRIDE   = 4;
	localparam logic [11:0] IDX_IN_BASE  = 12'hfd2;
	localparam logic [11:0] IDX_OUT_BASE = 12'hfd3;
	localparam logic [11:0] IDX_DIR_BASE = 12'h040;
	localparam logic [11:0] IDX_ALT_BASE = 12'h060;
	localparam logic [11:0] IDX_ODC_BASE = 12'h080;
	localparam logic [11:0] IDX_SMR_BASE = 12'h0a0;
	localparam logic [11:0] IDX_IRQ_STAT = 12'h0c0;
	localparam logic [11:0] IDX_IRQ_MASK = 12'h0c1;
	localparam logic [7:0]  PORT_RESET   = 8'h00;
	localparam int          IRQ_W        = 12;
	localparam int          IRQ_C_LSB    = 8;
	localparam int          IRQ_C_BITS   = 4;
	localparam int          WARM_W       = 3;
	localparam int          PORT_A       = 0;
	localparam int          PORT_B       = 1;
	localparam int          PORT_C       = 2;
	localparam int          PORT_D       = 3;
	localparam int          BIT_T0_IN    = 0;
	localparam int          BIT_T0_OUT   = 1;
	localparam int          BIT_DE       = 2;
	localparam int          BIT_CTS      = 3;
	localparam int          BIT_RXD      = 4;
	localparam int          BIT_TXD      = 5;
	localparam int          BIT_SCL      = 6;
	localparam int          BIT_SDA      = 7;
endpackage : gpio_pkg

// *** design/gpio_port_data_altfunc.sv ***
// bank of eight-bit ports with alternate functions, edge irqs, apb slave
`timescale 1ns/100ps

// Notes on behaviour
// - alternate function pins take direction from their peripheral
// - input register read returns synchronised pin levels, bit n is pin n
// - input register is read-only; writes leave it untouched
// - output bit reaches pin only for output pins without alternate use
// - zero drives low, one drives high unless open-drain selected
// - output register is read/write, eight bits, cleared on reset
// - port A bits 6 and 7 in alternate use are forced open-drain
// - port A alternate map to timer 0, serial 0 and two-wire; port B analog
// - input registers at index fd2 onward, four apart, port H at fee
// - enabled pin edge during stop mode starts a recovery
// - either edge on A or D bit n raises shared request n
// - port C bits 0 to 3 each raise own request on both edges
module gpio_port_data_altfunc
	import gpio_pkg::*;
#(
	parameter int NUM_PORTS = 8
)(
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [APB_ADDR_W-1:0]       paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [NUM_PORTS*PORT_W-1:0] pin_in,
	output logic      [NUM_PORTS*PORT_W-1:0] pin_out,
	output logic      [NUM_PORTS*PORT_W-1:0] pin_oe_n,
	output logic                             timer0_input_pin,
	output logic                             serial0_clear_to_send,
	output logic                             serial0_receive_line,
	input  wire logic                        timer0_output_pin,
	input  wire logic                        serial0_driver_enable,
	input  wire logic                        serial0_transmit_line,
	input  wire logic                        scl_pull_low,
	input  wire logic                        sda_pull_low,
	output logic      [PORT_W-1:0]           analog_in_sel,
	output logic      [(NUM_PORTS-2)*PORT_W-1:0] alt_in,
	input  wire logic [(NUM_PORTS-2)*PORT_W-1:0] alt_out,
	input  wire logic [(NUM_PORTS-2)*PORT_W-1:0] alt_drive,
	input  wire logic                        stop_mode,
	output logic                             stop_recovery,
	output logic      [IRQ_W-1:0]            edge_req,
	output logic                             irq
);
	localparam int W = NUM_PORTS * PORT_W;

	if (NUM_PORTS < 4 || NUM_PORTS > 8)
	begin : g_bad_ports
		$error("NUM_PORTS must lie between 4 and 8");
	end

	function automatic logic [IDX_W-1:0] reg_idx(logic [IDX_W-1:0] base,
		int p);
		reg_idx = base + IDX_W'(p * IDX_STRIDE);
	endfunction : reg_idx

	// pin synchroniser and sampled input register
	logic [W-1:0]      sync1_q;
	logic [W-1:0]      sync2_q;
	logic [W-1:0]      sample_q;
	logic [WARM_W-1:0] warm_q;
	logic [WARM_W-1:0] warm_d;
	logic [W-1:0]      pin_edge;

	always_comb
	begin
		warm_d = {warm_q[WARM_W-2:0], 1'b1};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_q  <= '0;
			sync2_q  <= '0;
			sample_q <= '0;
			warm_q   <= '0;
		end
		else
		begin
			sync1_q  <= pin_in;
			sync2_q  <= sync1_q;
			sample_q <= sync2_q;
			warm_q   <= warm_d;
		end
	end

	// edges count only once the pipeline holds real pin levels
	assign pin_edge = (sync2_q ^ sample_q) & {W{warm_q[WARM_W-1]}};

	// configuration and interrupt registers, apb decode
	logic [W-1:0]       out_q, out_d;
	logic [W-1:0]       dir_q, dir_d;
	logic [W-1:0]       alt_q, alt_d;
	logic [W-1:0]       odc_q, odc_d;
	logic [W-1:0]       smr_q, smr_d;
	logic [IRQ_W-1:0]   stat_q, stat_d;
	logic [IRQ_W-1:0]   mask_q, mask_d;
	logic [31:0]        prdata_q, prdata_d;
	logic [IRQ_W-1:0]   rd_val;
	logic [IRQ_W-1:0]   ev;
	logic [IDX_W-1:0]   idx;
	logic               hit;
	logic               wr;
	logic [PORT_W-1:0]  wbyte;

	assign idx   = paddr[APB_ADDR_W-1:2];
	assign wbyte = pwdata[PORT_W-1:0];
	assign wr    = psel & penable & pwrite & (paddr[1:0] == 2'b00);

	always_comb
	begin
		for (int n = 0; n < PORT_W; n++)
		begin
			ev[n] = pin_edge[PORT_A*PORT_W+n]
				| pin_edge[PORT_D*PORT_W+n];
		end
		for (int k = 0; k < IRQ_C_BITS; k++)
		begin
			ev[IRQ_C_LSB+k] = pin_edge[PORT_C*PORT_W+k];
		end
	end

	always_comb
	begin
		out_d  = out_q;
		dir_d  = dir_q;
		alt_d  = alt_q;
		odc_d  = odc_q;
		smr_d  = smr_q;
		mask_d = mask_q;
		stat_d = stat_q;
		hit    = 1'b0;
		rd_val = '0;
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			// writes to the sample register are dropped
			if (idx == reg_idx(IDX_IN_BASE, p))
			begin
				hit    = 1'b1;
				rd_val = IRQ_W'(sample_q[p*PORT_W +: PORT_W]);
			end
			if (idx == reg_idx(IDX_OUT_BASE, p))
			begin
				hit    = 1'b1;
				rd_val = IRQ_W'(out_q[p*PORT_W +: PORT_W]);
				if (wr)
				begin
					out_d[p*PORT_W +: PORT_W] = wbyte;
				end
			end
			if (idx == reg_idx(IDX_DIR_BASE, p))
			begin
				hit    = 1'b1;
				rd_val = IRQ_W'(dir_q[p*PORT_W +: PORT_W]);
				if (wr)
				begin
					dir_d[p*PORT_W +: PORT_W] = wbyte;
				end
			end
			if (idx == reg_idx(IDX_ALT_BASE, p))
			begin
				hit    = 1'b1;
				rd_val = IRQ_W'(alt_q[p*PORT_W +: PORT_W]);
				if (wr)
				begin
					alt_d[p*PORT_W +: PORT_W] = wbyte;
				end
			end
			if (idx == reg_idx(IDX_ODC_BASE, p))
			begin
				hit    = 1'b1;
				rd_val = IRQ_W'(odc_q[p*PORT_W +: PORT_W]);
				if (wr)
				begin
					odc_d[p*PORT_W +: PORT_W] = wbyte;
				end
			end
			if (idx == reg_idx(IDX_SMR_BASE, p))
			begin
				hit    = 1'b1;
				rd_val = IRQ_W'(smr_q[p*PORT_W +: PORT_W]);
				if (wr)
				begin
					smr_d[p*PORT_W +: PORT_W] = wbyte;
				end
			end
		end
		if (idx == IDX_IRQ_STAT)
		begin
			hit    = 1'b1;
			rd_val = stat_q;
			if (wr)
			begin
				stat_d = stat_q & ~pwdata[IRQ_W-1:0];
			end
		end
		if (idx == IDX_IRQ_MASK)
		begin
			hit    = 1'b1;
			rd_val = mask_q;
			if (wr)
			begin
				mask_d = pwdata[IRQ_W-1:0];
			end
		end
		// a new edge wins over a clear in the same cycle
		stat_d = stat_d | ev;
		prdata_d = prdata_q;
		if (psel && !penable)
		begin
			prdata_d = (hit && paddr[1:0] == 2'b00) ? 32'(rd_val) : '0;
		end
	end

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~(hit & (paddr[1:0] == 2'b00));
	assign prdata  = prdata_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_q    <= {NUM_PORTS{PORT_RESET}};
			dir_q    <= {NUM_PORTS{PORT_RESET}};
			alt_q    <= {NUM_PORTS{PORT_RESET}};
			odc_q    <= {NUM_PORTS{PORT_RESET}};
			smr_q    <= {NUM_PORTS{PORT_RESET}};
			stat_q   <= '0;
			mask_q   <= '0;
			prdata_q <= '0;
		end
		else
		begin
			out_q    <= out_d;
			dir_q    <= dir_d;
			alt_q    <= alt_d;
			odc_q    <= odc_d;
			smr_q    <= smr_d;
			stat_q   <= stat_d;
			mask_q   <= mask_d;
			prdata_q <= prdata_d;
		end
	end

	// pin drivers, peripheral routing and event outputs
	logic [W-1:0]     alt_val, alt_en, od, dval, don;
	logic [W-1:0]     pin_out_q, oe_n_q, oe_n_d;
	logic [IRQ_W-1:0] edge_req_q;
	logic             recov_q, recov_d, irq_q, irq_d;

	always_comb
	begin
		alt_val = '0;
		alt_en  = '0;
		alt_val[BIT_T0_OUT] = timer0_output_pin;
		alt_en[BIT_T0_OUT]  = 1'b1;
		alt_val[BIT_DE]     = serial0_driver_enable;
		alt_en[BIT_DE]      = 1'b1;
		alt_val[BIT_TXD]    = serial0_transmit_line;
		alt_en[BIT_TXD]     = 1'b1;
		alt_en[BIT_SCL]     = scl_pull_low;
		alt_en[BIT_SDA]     = sda_pull_low;
		alt_val[W-1:PORT_C*PORT_W] = alt_out;
		alt_en[W-1:PORT_C*PORT_W]  = alt_drive;
		od = odc_q;
		od[BIT_SCL] = odc_q[BIT_SCL] | alt_q[BIT_SCL];
		od[BIT_SDA] = odc_q[BIT_SDA] | alt_q[BIT_SDA];
		dval = (alt_q & alt_val) | (~alt_q & out_q);
		don  = (alt_q & alt_en) | (~alt_q & dir_q);
		oe_n_d = ~(don & ~(od & dval));
		recov_d = stop_mode & (|(pin_edge & smr_q));
		irq_d   = |(stat_d & mask_d);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_out_q  <= '0;
			oe_n_q     <= '1;
			edge_req_q <= '0;
			recov_q    <= 1'b0;
			irq_q      <= 1'b0;
		end
		else
		begin
			pin_out_q  <= dval;
			oe_n_q     <= oe_n_d;
			edge_req_q <= ev;
			recov_q    <= recov_d;
			irq_q      <= irq_d;
		end
	end

	assign pin_out       = pin_out_q;
	assign pin_oe_n      = oe_n_q;
	assign edge_req      = edge_req_q;
	assign stop_recovery = recov_q;
	assign irq           = irq_q;
	assign timer0_input_pin      = sample_q[BIT_T0_IN];
	assign serial0_clear_to_send = sample_q[BIT_CTS];
	assign serial0_receive_line  = sample_q[BIT_RXD];
	assign analog_in_sel = alt_q[PORT_B*PORT_W +: PORT_W];
	assign alt_in        = sample_q[W-1:PORT_C*PORT_W];

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup(logic [IDX_W-1:0] ix, logic dirw);
		psel && !penable && pwrite == dirw && paddr[1:0] == 2'b00
			&& idx == ix;
	endsequence

	property p_out_write;
		s_setup(IDX_OUT_BASE, 1'b1) ##1 penable |=>
			out_q[PORT_W-1:0] == $past(pwdata[PORT_W-1:0]);
	endproperty
	a_out_write: assert property (p_out_write)
		else $error("output register write not stored");

	property p_in_read;
		s_setup(IDX_IN_BASE, 1'b0) |=>
			prdata == 32'($past(sample_q[PORT_W-1:0])) && !pslverr;
	endproperty
	a_in_read: assert property (p_in_read)
		else $error("input register read mismatch");

	property p_in_ro;
		s_setup(IDX_IN_BASE, 1'b1) |=> ##1
			sample_q == $past(sync2_q);
	endproperty
	a_in_ro: assert property (p_in_ro)
		else $error("input register altered by write");

	property p_sync_depth;
		warm_q[WARM_W-1] |-> sample_q == $past(pin_in, 3);
	endproperty
	a_sync_depth: assert property (p_sync_depth)
		else $error("pin sample not three cycles behind pin");

	property p_no_drive;
		1'b1 |=> ((~pin_oe_n) & ~$past(alt_q | dir_q)) == '0
			&& ((~pin_oe_n) & ~$past(alt_q) & (pin_out ^ $past(out_q))) == '0;
	endproperty
	a_no_drive: assert property (p_no_drive)
		else $error("pin driven from output register wrongly");

	property p_open_drain;
		1'b1 |=> ((~pin_oe_n) & pin_out & $past(odc_q)) == '0;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("open-drain pin driven high");

	// data line in two-wire use: pulled low on request, else released
	property p_twowire_od;
		alt_q[BIT_SDA] |=> pin_oe_n[BIT_SDA] == !$past(sda_pull_low)
			&& !(!pin_oe_n[BIT_SDA] && pin_out[BIT_SDA]);
	endproperty
	a_twowire_od: assert property (p_twowire_od)
		else $error("two-wire data line driven high");

	property p_alt_dir;
		alt_q[BIT_T0_OUT] && !odc_q[BIT_T0_OUT] |=> !pin_oe_n[BIT_T0_OUT]
			&& pin_out[BIT_T0_OUT] == $past(timer0_output_pin);
	endproperty
	a_alt_dir: assert property (p_alt_dir)
		else $error("alternate output not routed to pin");

	sequence s_edge(int b);
		warm_q[WARM_W-1] && sync2_q[b] != sample_q[b];
	endsequence

	property p_ad_irq;
		s_edge(PORT_D*PORT_W) |=> stat_q[0] && edge_req[0];
	endproperty
	a_ad_irq: assert property (p_ad_irq)
		else $error("port D edge did not raise request");

	property p_c_irq;
		s_edge(PORT_C*PORT_W+3) |=> stat_q[IRQ_C_LSB+3]
			&& edge_req[IRQ_C_LSB+3];
	endproperty
	a_c_irq: assert property (p_c_irq)
		else $error("port C edge did not raise request");

	property p_stop_recov;
		s_edge(0) ##0 stop_mode && smr_q[0] |=> stop_recovery;
	endproperty
	a_stop_recov: assert property (p_stop_recov)
		else $error("stop recovery not started");
endmodule : gpio_port_data_altfunc

// *** dv/pin_world.sv ***
// board model for the port pins: pull-ups plus optional bench drive
`timescale 1ns/100ps
module pin_world #(
	parameter int W = 64
)(
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] pin_oe_n,
	input  wire logic [W-1:0] ext_val,
	input  wire logic [W-1:0] ext_en,
	output logic      [W-1:0] pin_in
);
	// device drive wins, then the bench source, else the pull-up
	always_comb
	begin
		for (int i = 0; i < W; i++)
			pin_in[i] = !pin_oe_n[i] ? pin_out[i]
				: (ext_en[i] ? ext_val[i] : 1'b1);
	end
endmodule : pin_world

// *** dv/tb_gpio_port_data_altfunc.sv ***
// self-checking bench for the port bank
`timescale 1ns/100ps
module tb_gpio_port_data_altfunc;
	import gpio_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [63:0] pin_in, pin_out, pin_oe_n, ext_val, ext_en;
	logic        timer0_output_pin, serial0_driver_enable;
	logic        serial0_transmit_line, scl_pull_low, sda_pull_low;
	logic [7:0]  analog_in_sel;
	logic        timer0_input_pin, serial0_clear_to_send;
	logic        serial0_receive_line;
	logic [47:0] alt_in, alt_out, alt_drive;
	logic        stop_mode, stop_recovery, irq;
	logic [11:0] edge_req;
	logic [32:0] rq[$];
	logic [11:0] eq[$];
	logic [7:0]  rs = 8'h52;
	logic        edge_chk = 1'b0;
	int          mismatches = 0;
	int          comparisons = 0;
	int          rec_cnt = 0;
	localparam int          EP[5] = '{0, 24, 31, 19, 16};
	localparam logic [11:0] EE[5] = '{12'h001, 12'h001, 12'h080,
		12'h800, 12'h100};

	gpio_port_data_altfunc #(.NUM_PORTS(8)) dut_u (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n,
		.timer0_input_pin, .serial0_clear_to_send,
		.serial0_receive_line, .timer0_output_pin,
		.serial0_driver_enable, .serial0_transmit_line, .scl_pull_low,
		.sda_pull_low, .analog_in_sel, .alt_in, .alt_out, .alt_drive,
		.stop_mode, .stop_recovery, .edge_req, .irq);
	pin_world #(.W(64)) world_u (.pin_out, .pin_oe_n, .ext_val, .ext_en,
		.pin_in);

	initial
	begin
		pclk = 1'b0;
		forever
			#5 pclk = ~pclk;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	function automatic logic [11:0] ix(input logic [11:0] b, input int p);
		return b + 12'(IDX_STRIDE * p);
	endfunction : ix

	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	task automatic bad(input string m);
		mismatches++;
		$display("ERROR %0t %s", $time, m);
	endtask : bad

	task automatic chk(input logic [63:0] got, input logic [63:0] exp,
		input string m);
		comparisons++;
		if (got !== exp)
			bad(m);
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	task automatic apb(input logic w, input logic [11:0] idx,
		input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rd(input logic [11:0] idx, input logic [31:0] exp,
		input logic err = 1'b0);
		rq.push_back({err, exp});
		apb(1'b0, idx, 32'h0);
	endtask : rd

	task automatic pchk(input int p, input logic [7:0] oe,
		input logic [7:0] v);
		cyc(2);
		chk(pin_oe_n[p*8+:8], oe, "output enable");
		chk(pin_out[p*8+:8] & ~oe, v & ~oe, "drive level");
	endtask : pchk

	// read data and edge pulses are matched against the oldest note
	always @(posedge pclk)
	begin
		if (psel && penable && pready && !pwrite)
		begin
			comparisons++;
			if (rq.size() == 0)
				bad("unexpected read");
			else if ({pslverr, prdata} !== rq.pop_front())
				bad("read data");
		end
		if (edge_chk && edge_req !== 12'h000)
		begin
			comparisons++;
			if (eq.size() == 0)
				bad("unexpected edge request");
			else if (edge_req !== eq.pop_front())
				bad("edge request");
		end
		if (stop_recovery === 1'b1)
			rec_cnt++;
	end

	initial
	begin
		#100000;
		mismatches++;
		stop_test();
	end

	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{ext_val, ext_en, alt_out, alt_drive, stop_mode} = '0;
		{timer0_output_pin, serial0_driver_enable} = '0;
		{serial0_transmit_line, scl_pull_low, sda_pull_low} = '0;
		cyc(5);
		presetn <= 1'b1;
		cyc(5);
		chk(pin_oe_n, '1, "released after reset");
		edge_chk <= 1'b1;
		apb(1'b1, IDX_IRQ_MASK, 32'h101);
		for (int i = 0; i < 5; i++)
		begin
			ext_en[EP[i]] <= 1'b1;
			eq.push_back(EE[i]);
			cyc(6);
			chk(irq, |(EE[i] & 12'h101), "irq level");
			rd(IDX_IRQ_STAT, {20'h0, EE[i]});
			apb(1'b1, IDX_IRQ_STAT, 32'hfff);
			cyc(2);
			chk(irq, 0, "irq cleared");
		end
		chk(64'(eq.size()), 0, "edge request missing");
		edge_chk <= 1'b0;
		$display("test edges finished");
		apb(1'b1, ix(IDX_SMR_BASE, 0), 32'h01);
		stop_mode <= 1'b1;
		ext_val[0] <= 1'b1;
		cyc(6);
		chk(rec_cnt, 1, "recovery on enabled pin");
		ext_en[1] <= 1'b1;
		cyc(6);
		chk(rec_cnt, 1, "recovery on disabled pin");
		stop_mode <= 1'b0;
		ext_val[0] <= 1'b0;
		cyc(6);
		chk(rec_cnt, 1, "recovery outside stop");
		$display("test recovery finished");
		for (int p = 0; p < 8; p++)
		begin
			rs = lfsr(rs);
			ext_en[p*8+:8] <= 8'hff;
			ext_val[p*8+:8] <= rs;
			cyc(4);
			if (p == PORT_A)
				chk({serial0_receive_line, serial0_clear_to_send,
					timer0_input_pin}, {rs[BIT_RXD], rs[BIT_CTS],
					rs[BIT_T0_IN]}, "port A peripheral inputs");
			else if (p >= PORT_C)
				chk(alt_in[(p-PORT_C)*8+:8], rs, "alt inputs");
			rd(ix(IDX_IN_BASE, p), {24'h0, rs});
			apb(1'b1, ix(IDX_IN_BASE, p), {24'h0, ~rs});
			rd(ix(IDX_IN_BASE, p), {24'h0, rs});
			rd(ix(IDX_OUT_BASE, p), 32'h0);
			rs = lfsr(rs);
			apb(1'b1, ix(IDX_OUT_BASE, p), {24'hffffff, rs});
			rd(ix(IDX_OUT_BASE, p), {24'h0, rs});
		end
		rd(12'h3ff, 32'h0, 1'b1);
		$display("test registers finished");
		apb(1'b1, ix(IDX_OUT_BASE, 4), 32'ha5);
		apb(1'b1, ix(IDX_DIR_BASE, 4), 32'h0f);
		pchk(4, 8'hf0, 8'ha5);
		apb(1'b1, ix(IDX_ODC_BASE, 4), 32'hff);
		pchk(4, 8'hf5, 8'h00);
		apb(1'b1, ix(IDX_ODC_BASE, 4), 32'h00);
		alt_drive[16+:8] <= 8'h3c;
		alt_out[16+:8] <= 8'hff;
		apb(1'b1, ix(IDX_ALT_BASE, 4), 32'hff);
		pchk(4, 8'hc3, 8'hff);
		apb(1'b1, ix(IDX_DIR_BASE, 1), 32'hff);
		apb(1'b1, ix(IDX_ALT_BASE, 1), 32'hff);
		pchk(1, 8'hff, 8'h00);
		chk(analog_in_sel, 8'hff, "analog select");
		timer0_output_pin <= 1'b1;
		serial0_driver_enable <= 1'b1;
		serial0_transmit_line <= 1'b1;
		scl_pull_low <= 1'b1;
		apb(1'b1, ix(IDX_ALT_BASE, 0), 32'hff);
		pchk(0, 8'h99, 8'h26);
		scl_pull_low <= 1'b0;
		sda_pull_low <= 1'b1;
		pchk(0, 8'h59, 8'h26);
		$display("test pin drive finished");
		stop_test();
	end
endmodule : tb_gpio_port_data_altfunc
